// >>> rtl/pli_regs.svh
// Register offsets, field positions, reset values and timing constants of the indicator block
`ifndef PLI_REGS_SVH
`define PLI_REGS_SVH

// ==========================================================================
// Register port widths
`define PLI_ADDR_W        5
`define PLI_DATA_W        16

// ==========================================================================
// Register offsets
`define PLI_OFF_BMCTL     5'h00
`define PLI_OFF_PHY_STATUS    5'h10
`define PLI_OFF_INTCTL    5'h11
`define PLI_OFF_INTSTM    5'h12
`define PLI_OFF_LEDDIR    5'h18
`define PLI_OFF_PHYCTL    5'h19
`define PLI_OFF_SDCFG     5'h1C

// ==========================================================================
// Field positions
`define PLI_BMC_LOOPBACK  14
`define PLI_BMC_PWRDN     11
`define PLI_INT_OE        0
`define PLI_INT_EN        1
`define PLI_IST_FLAG_LO   8
`define PLI_LDC_ACT_RX    8
`define PLI_LDC_BLINK_LO  6
`define PLI_LDC_FORCE_LO  3
`define PLI_LDC_VAL_LO    0
`define PLI_PHC_MODE_LO   5
`define PLI_SDC_FAST      8
`define PLI_STS_LINK      0
`define PLI_STS_SPD10     1
`define PLI_STS_DUPLEX    2
`define PLI_STS_LOOPBACK  3
`define PLI_STS_PWRDN     4

// Interrupt event positions (flag = position + 8, mask = position)
`define PLI_EV_RXERR      0
`define PLI_EV_COL        1
`define PLI_EV_SPEED      2
`define PLI_EV_DUPLEX     3
`define PLI_EV_PWRDN      4
`define PLI_EV_LINK       5
`define PLI_EV_ENERGY     6
`define PLI_EV_RSVD       7

// LED index
`define PLI_LINK_INDICATOR      0
`define PLI_LED_SPEED     1
`define PLI_ACTIVITY_INDICATOR       2

// ==========================================================================
// Reset values
`define PLI_BMCTL_RST     16'h0000
`define PLI_INTCTL_RST    16'h0000
`define PLI_MASK_RST      8'h00
`define PLI_LEDDIR_RST    16'h0000
`define PLI_PHYCTL_RST    16'h0020
`define PLI_SDCFG_RST     16'h0000

// ==========================================================================
// Timing
`define PLI_CLK_KHZ       40000
`define PLI_FAST_LOSS_NS  1300
`define PLI_LINK_LOSS_US  50000
`define PLI_BLINK_UNIT_US 25000
`define PLI_NLP_GOOD      7
// Blink half periods in blink units, per rate select value
`define PLI_BLINK_R0      20
`define PLI_BLINK_R1      10
`define PLI_BLINK_R2      5
`define PLI_BLINK_R3      2

`endif

// >>> rtl/pli_pkg.sv
// Types of the indicator, loopback and interrupt block
package pli_pkg;

  // ========================================================================
  // Indicator mode, Gray coded
  typedef enum logic [1:0] {
    PLI_MODE2 = 2'b00,
    PLI_MODE1 = 2'b01,
    PLI_MODE3 = 2'b11
  } pli_led_mode_t;

  // ========================================================================
  // Media independent interface bundles
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } pli_mii_tx_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic       crs;
    logic       col;
    logic [3:0] d;
  } pli_mii_rx_t;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [15:0] bmctl;
    logic [15:0] intctl;
    logic [7:0]  mask;
    logic [7:0]  flags;
    logic [15:0] leddir;
    logic [15:0] phyctl;
    logic [15:0] sdcfg;
    logic [15:0] rdata;
    logic        link;
    logic [2:0]  nlp_cnt;
    logic [31:0] loss_cnt;
    logic [31:0] blink_cnt;
    logic        blink_ph;
    logic [2:0]  strap;
    logic        strap_ok;
    logic [2:0]  led;
    pli_mii_rx_t rx;
    pli_mii_tx_t tx;
    logic        prev_spd;
    logic        prev_dup;
    logic        prev_link;
    logic        prev_energy;
    logic        prev_pd;
    logic        prev_col;
    logic        prev_rxer;
  } pli_state_t;

endpackage : pli_pkg

// >>> rtl/pli_core.sv
// Indicator LEDs, MII loopback and power-down / interrupt pin of a 10/100 transceiver
//
// Summary of operation
// - 10M link after seven pulses or packet
// - 100M link follows internal signal detect
// - Fast loss drops link within 1.3 us
// - Modes 2/3 link steady, blinks on activity
// - Blink rate from bits 7:6 at 18h
// - Bit 8 selects receive-only activity
// - Speed LED on at 100M, any mode
// - Activity LED: activity mode1, collision mode2
// - Mode 3 activity LED shows full duplex
// - 10M half-duplex collision comes from COL
// - LED polarity from strap sampled at reset
// - Direct LED force; reads return register only
// - Loopback bit routes transmit to receive
// - Loopback status in status bit 3
// - Shared pin input until output-enable set
// - Pin low powers down like control bit
// - Output enable ends pin-induced power down
// - Interrupts off at reset, enable plus masks
// - Enabled event sets flag, pin low immediately
// - Status read clears flags, pin returns high
// - Mode from bits 6:5 at 19h
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "pli_regs.svh"

module pli_core #(
  parameter int LINK_LOSS_CYC  = `PLI_LINK_LOSS_US * (`PLI_CLK_KHZ / 1000),
  parameter int BLINK_UNIT_CYC = `PLI_BLINK_UNIT_US * (`PLI_CLK_KHZ / 1000)
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Register port
  input  wire logic [`PLI_ADDR_W-1:0]   reg_addr,
  input  wire logic [`PLI_DATA_W-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [`PLI_DATA_W-1:0]   reg_rdata,
  // Line status from the receivers
  input  wire logic                     speed_100,
  input  wire logic                     full_duplex,
  input  wire logic                     signal_detect,
  input  wire logic                     link_pulse,
  input  wire logic                     link_pulse_bad,
  input  wire logic                     rx_packet_ok,
  input  wire logic                     energy_state,
  // MII from the MAC and toward the media
  input  wire pli_pkg::pli_mii_tx_t     mii_tx,
  output pli_pkg::pli_mii_tx_t          media_tx,
  // MII from the line receiver and toward the MAC
  input  wire pli_pkg::pli_mii_rx_t     line_rx,
  output pli_pkg::pli_mii_rx_t          mii_rx,
  // Indicator pins, shared with the negotiation straps
  input  wire logic [2:0]               indicator_i,
  output logic      [2:0]               indicator_o,
  output logic      [2:0]               indicator_oe,
  // Shared power-down input / interrupt output pin
  input  wire logic                     powerdown_irq_pin_i,
  output logic                          powerdown_irq_pin_o,
  output logic                          powerdown_irq_pin_oe,
  // Power-down request to the rest of the transceiver
  output logic                          power_down
);

  localparam int FAST_LOSS_CYC =
    (`PLI_FAST_LOSS_NS * (`PLI_CLK_KHZ / 1000)) / 1000;

  localparam pli_pkg::pli_state_t STATE_RST = '{
    bmctl:   `PLI_BMCTL_RST,
    intctl:  `PLI_INTCTL_RST,
    mask:    `PLI_MASK_RST,
    leddir:  `PLI_LEDDIR_RST,
    phyctl:  `PLI_PHYCTL_RST,
    sdcfg:   `PLI_SDCFG_RST,
    default: '0
  };

  // ========================================================================
  // LED pin level: strap high means an active-low driver
  function automatic logic pli_led_level(input logic on, input logic strap);
    pli_led_level = on ^ strap;
  endfunction : pli_led_level

  // Mode field decode: low bit set always means mode 1
  function automatic pli_pkg::pli_led_mode_t pli_mode_of(input logic [1:0] cfg);
    pli_mode_of = cfg[0] ? pli_pkg::PLI_MODE1 :
                  (cfg[1] ? pli_pkg::PLI_MODE3 : pli_pkg::PLI_MODE2);
  endfunction : pli_mode_of

  pli_pkg::pli_state_t    st_q;
  pli_pkg::pli_state_t    st_d;
  pli_pkg::pli_led_mode_t mode;
  logic                   pin_pd;
  logic                   pd_now;
  logic                   loopback;
  logic                   activity;
  logic                   collision;
  logic                   alive;
  logic [31:0]            loss_lim;
  logic [31:0]            blink_lim;
  logic [7:0]             events;
  logic [7:0]             set_fl;
  logic [2:0]             led_on;
  logic [2:0]             led_frc;
  logic [15:0]            sts;

  // ========================================================================
  // Shared pin and power down; the input is ignored once it drives
  always_comb
  begin
    pin_pd = ~st_q.intctl[`PLI_INT_OE] & ~powerdown_irq_pin_i;
    pd_now = st_q.bmctl[`PLI_BMC_PWRDN] | pin_pd;
  end

  assign power_down           = pd_now;
  assign powerdown_irq_pin_oe = st_q.intctl[`PLI_INT_OE];
  // Combinational so the pin falls in the cycle a flag is present
  assign powerdown_irq_pin_o  = ~(st_q.intctl[`PLI_INT_EN] & (|st_q.flags));

  // ========================================================================
  // Line-derived conditions
  always_comb
  begin
    loopback = st_q.bmctl[`PLI_BMC_LOOPBACK];
    mode     = pli_mode_of(st_q.phyctl[`PLI_PHC_MODE_LO +: 2]);
    // Receive side as the MAC sees it, so loopback traffic counts too
    if (st_q.leddir[`PLI_LDC_ACT_RX])
      activity = st_q.rx.crs | st_q.rx.dv;
    else
      activity = st_q.rx.crs | st_q.rx.dv | mii_tx.en;
    collision = line_rx.col & ~full_duplex;
    // In 100M the detect level keeps the link, in 10M each pulse or packet
    alive    = speed_100 ? signal_detect : (link_pulse | rx_packet_ok);
    loss_lim = (speed_100 && st_q.sdcfg[`PLI_SDC_FAST]) ?
               32'(FAST_LOSS_CYC) : 32'(LINK_LOSS_CYC);
    unique case (st_q.leddir[`PLI_LDC_BLINK_LO +: 2])
      2'b00: blink_lim = 32'(BLINK_UNIT_CYC * `PLI_BLINK_R0);
      2'b01: blink_lim = 32'(BLINK_UNIT_CYC * `PLI_BLINK_R1);
      2'b10: blink_lim = 32'(BLINK_UNIT_CYC * `PLI_BLINK_R2);
      2'b11: blink_lim = 32'(BLINK_UNIT_CYC * `PLI_BLINK_R3);
    endcase
  end

  // ========================================================================
  // Interrupt events, all edge detected against the previous cycle
  always_comb
  begin
    events                  = '0;
    events[`PLI_EV_RXERR]   = line_rx.er & ~st_q.prev_rxer;
    events[`PLI_EV_COL]     = collision & ~st_q.prev_col;
    events[`PLI_EV_SPEED]   = speed_100 ^ st_q.prev_spd;
    events[`PLI_EV_DUPLEX]  = full_duplex ^ st_q.prev_dup;
    events[`PLI_EV_PWRDN]   = pd_now ^ st_q.prev_pd;
    events[`PLI_EV_LINK]    = st_q.link ^ st_q.prev_link;
    events[`PLI_EV_ENERGY]  = energy_state ^ st_q.prev_energy;
    set_fl                  = events & st_q.mask;
  end

  // ========================================================================
  // Indicator functions before forcing and polarity
  always_comb
  begin
    // Dark by default so that an unused mode code cannot infer a latch
    led_on                 = '0;
    led_on[`PLI_LED_SPEED] = speed_100;
    unique case (mode)
      pli_pkg::PLI_MODE1:
      begin
        led_on[`PLI_LINK_INDICATOR] = st_q.link;
        led_on[`PLI_ACTIVITY_INDICATOR]  = activity;
      end
      pli_pkg::PLI_MODE2:
      begin
        led_on[`PLI_LINK_INDICATOR] = st_q.link & ~(activity & st_q.blink_ph);
        led_on[`PLI_ACTIVITY_INDICATOR]  = collision;
      end
      pli_pkg::PLI_MODE3:
      begin
        led_on[`PLI_LINK_INDICATOR] = st_q.link & ~(activity & st_q.blink_ph);
        led_on[`PLI_ACTIVITY_INDICATOR]  = full_duplex;
      end
    endcase
  end

  // Direct control overrides each LED on its own
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_led
      assign led_frc[gi] = st_q.leddir[`PLI_LDC_FORCE_LO + gi] ?
                           st_q.leddir[`PLI_LDC_VAL_LO + gi] : led_on[gi];
      assign indicator_o[gi]  = st_q.led[gi];
      // Not driven until the strap has been read, so the strap level is clean
      assign indicator_oe[gi] = st_q.strap_ok;
    end
  endgenerate

  // ========================================================================
  // Status register view
  always_comb
  begin
    sts                    = '0;
    sts[`PLI_STS_LINK]     = st_q.link;
    sts[`PLI_STS_SPD10]    = ~speed_100;
    sts[`PLI_STS_DUPLEX]   = full_duplex;
    sts[`PLI_STS_LOOPBACK] = loopback;
    sts[`PLI_STS_PWRDN]    = pd_now;
  end

  // ========================================================================
  // Next state
  always_comb
  begin
    st_d = st_q;

    // Strap capture in the first cycle after reset release
    if (!st_q.strap_ok)
    begin
      st_d.strap    = indicator_i;
      st_d.strap_ok = 1'b1;
    end

    // Link qualification and loss timing
    if (alive)
      st_d.loss_cnt = '0;
    else if (st_q.loss_cnt < loss_lim)
      st_d.loss_cnt = st_q.loss_cnt + 32'h00000001;
    if (link_pulse_bad)
      st_d.nlp_cnt = '0;
    else if (link_pulse && st_q.nlp_cnt < 3'(`PLI_NLP_GOOD))
      st_d.nlp_cnt = st_q.nlp_cnt + 3'h1;
    if (speed_100)
    begin
      if (signal_detect)
        st_d.link = 1'b1;
    end
    else if (rx_packet_ok ||
             (link_pulse && st_q.nlp_cnt >= 3'(`PLI_NLP_GOOD - 1)))
      st_d.link = 1'b1;
    if (!alive && st_q.loss_cnt >= loss_lim - 32'h00000001)
    begin
      st_d.link    = 1'b0;
      st_d.nlp_cnt = '0;
    end

    // Blink phase runs only while there is something to blink for
    if (!activity)
    begin
      st_d.blink_cnt = '0;
      st_d.blink_ph  = 1'b0;
    end
    else if (st_q.blink_cnt >= blink_lim - 32'h00000001)
    begin
      st_d.blink_cnt = '0;
      st_d.blink_ph  = ~st_q.blink_ph;
    end
    else
      st_d.blink_cnt = st_q.blink_cnt + 32'h00000001;

    // Registered LED pins with strap polarity
    for (int i = 0; i < 3; i++)
      st_d.led[i] = pli_led_level(led_frc[i], st_q.strap[i]);

    // Loopback: transmit returns to the MAC, media sees nothing
    if (loopback)
    begin
      st_d.rx     = '{dv: mii_tx.en, er: mii_tx.er, crs: mii_tx.en,
                      col: 1'b0, d: mii_tx.d};
      st_d.tx     = '0;
    end
    else
    begin
      st_d.rx     = line_rx;
      st_d.tx     = pd_now ? '0 : mii_tx;
    end

    // Edge history for events
    st_d.prev_spd    = speed_100;
    st_d.prev_dup    = full_duplex;
    st_d.prev_link   = st_q.link;
    st_d.prev_energy = energy_state;
    st_d.prev_pd     = pd_now;
    st_d.prev_col    = collision;
    st_d.prev_rxer   = line_rx.er;

    // Register reads; data stands one cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `PLI_OFF_BMCTL:  st_d.rdata = st_q.bmctl;
        `PLI_OFF_PHY_STATUS: st_d.rdata = sts;
        `PLI_OFF_INTCTL: st_d.rdata = st_q.intctl;
        `PLI_OFF_INTSTM: st_d.rdata = {st_q.flags, st_q.mask};
        `PLI_OFF_LEDDIR: st_d.rdata = st_q.leddir;
        `PLI_OFF_PHYCTL: st_d.rdata = st_q.phyctl;
        `PLI_OFF_SDCFG:  st_d.rdata = st_q.sdcfg;
        default:         st_d.rdata = '0;
      endcase
    end

    // Flags: a read clears, a same-cycle event still lands
    if (reg_rd && reg_addr == `PLI_OFF_INTSTM)
      st_d.flags = set_fl;
    else
      st_d.flags = st_q.flags | set_fl;
    st_d.flags[`PLI_EV_RSVD] = 1'b0;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `PLI_OFF_BMCTL:  st_d.bmctl  = reg_wdata;
        `PLI_OFF_INTCTL: st_d.intctl = reg_wdata;
        `PLI_OFF_INTSTM: st_d.mask   = reg_wdata[7:0];
        `PLI_OFF_LEDDIR: st_d.leddir = reg_wdata;
        `PLI_OFF_PHYCTL: st_d.phyctl = reg_wdata;
        `PLI_OFF_SDCFG:  st_d.sdcfg  = reg_wdata;
        default:         st_d.bmctl  = st_q.bmctl;
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= STATE_RST;
    else
      st_q <= st_d;
  end

  assign reg_rdata = st_q.rdata;
  assign mii_rx    = st_q.rx;
  assign media_tx  = st_q.tx;

endmodule : pli_core

// >>> test/pli_core_sva.sv
// Port-level assertions for the indicator, loopback and interrupt block
`timescale 1ns/1ps

module pli_core_sva #(
  parameter int LINK_LOSS_CYC  = 100,
  parameter int BLINK_UNIT_CYC = 4
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // Register port
  input wire logic [4:0]           reg_addr,
  input wire logic [15:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  // Line status and MII
  input wire logic                 speed_100,
  input wire logic                 full_duplex,
  input wire logic                 energy_state,
  input wire pli_pkg::pli_mii_tx_t mii_tx,
  input wire pli_pkg::pli_mii_tx_t media_tx,
  input wire pli_pkg::pli_mii_rx_t mii_rx,
  // Pins
  input wire logic [2:0]           indicator_i,
  input wire logic [2:0]           indicator_o,
  input wire logic [2:0]           indicator_oe,
  input wire logic                 powerdown_irq_pin_i,
  input wire logic                 powerdown_irq_pin_o,
  input wire logic                 powerdown_irq_pin_oe,
  input wire logic                 power_down
);
  // ==========================================================================
  // Shadow registers
  logic [15:0] bmc_q;
  logic [15:0] ict_q;
  logic [15:0] ldc_q;
  logic [15:0] phc_q;
  logic [7:0]  msk_q;
  logic [2:0]  strap_q;
  logic        cap_q;

  // Follows the writes so that indicator checks know the mode and forces
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      {bmc_q, ict_q, ldc_q, msk_q, strap_q, cap_q} <= '0;
      phc_q <= 16'h0020;
    end
    else
    begin
      cap_q <= 1'b1;
      if (!cap_q)
        strap_q <= indicator_i; // Straps are read once, at the first edge
      if (reg_wr && reg_addr == 5'h00)
        bmc_q <= reg_wdata;
      if (reg_wr && reg_addr == 5'h11)
        ict_q <= reg_wdata;
      if (reg_wr && reg_addr == 5'h12)
        msk_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == 5'h18)
        ldc_q <= reg_wdata;
      if (reg_wr && reg_addr == 5'h19)
        phc_q <= reg_wdata;
    end

  // ==========================================================================
  // Properties
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_quiet;
    indicator_oe[0] && !power_down && $stable(ldc_q) && $stable(phc_q);
  endsequence
  sequence s_clear_read;
    reg_rd && reg_addr == 5'h12 && msk_q == 8'h40 && $stable(energy_state);
  endsequence

  property p_speed;
    s_quiet and !ldc_q[4] |=> indicator_o[1] == ($past(speed_100) ^ strap_q[1]);
  endproperty
  property p_force;
    s_quiet and ldc_q[3] |=> indicator_o[0] == ($past(ldc_q[0]) ^ strap_q[0]);
  endproperty
  property p_duplex;
    s_quiet and phc_q[6:5] == 2'b10 && !ldc_q[5]
      |=> indicator_o[2] == ($past(full_duplex) ^ strap_q[2]);
  endproperty
  property p_loop;
    bmc_q[14] && $stable(bmc_q) |=> media_tx == 6'h00 && mii_rx ==
      {$past(mii_tx.en), $past(mii_tx.er), $past(mii_tx.en), 1'b0, $past(mii_tx.d)};
  endproperty
  property p_pd;
    power_down == (bmc_q[11] || (!powerdown_irq_pin_i && !ict_q[0]));
  endproperty
  property p_oe;
    powerdown_irq_pin_oe == ict_q[0];
  endproperty
  property p_irq_set;
    $changed(energy_state) && msk_q[6] && ict_q[1] |=> !powerdown_irq_pin_o;
  endproperty
  property p_irq_clr;
    s_clear_read |=> powerdown_irq_pin_o;
  endproperty

  a_speed: assert property (p_speed) else $error("speed led wrong");
  a_force: assert property (p_force) else $error("forced led wrong");
  a_duplex: assert property (p_duplex) else $error("duplex led wrong");
  a_loop: assert property (p_loop) else $error("loopback path wrong");
  a_pd: assert property (p_pd) else $error("power down wrong");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_irq_set: assert property (p_irq_set) else $error("pin not low");
  a_irq_clr: assert property (p_irq_clr) else $error("pin not released");
endmodule : pli_core_sva

bind pli_core pli_core_sva #(
  .LINK_LOSS_CYC (LINK_LOSS_CYC),
  .BLINK_UNIT_CYC(BLINK_UNIT_CYC)
) pli_core_sva_i (.*);

// >>> test/pli_pins_model.sv
// Board around the indicator and power-down pins: straps, pull-up, external driver
`timescale 1ns/1ps

module pli_pins_model #(
  parameter logic [2:0] STRAP = 3'h2
) (
  // From the block
  input  wire logic [2:0] led_o,
  input  wire logic [2:0] led_oe,
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  // From the bench
  input  wire logic       pd_req,
  // Resolved pin levels
  output logic      [2:0] led_lvl,
  output logic            pin_lvl
);
  // Strap resistors show only while a pin is undriven; a strong low driver wins the shared pin
  always_comb
  begin
    for (int k = 0; k < 3; k++)
      led_lvl[k] = led_oe[k] ? led_o[k] : STRAP[k];
    pin_lvl = pin_oe ? (pin_o & !pd_req) : !pd_req;
  end
endmodule : pli_pins_model

// >>> test/pli_core_test.sv
// Self-checking bench for the indicator, loopback and interrupt block
`timescale 1ns/1ps

module pli_core_test;
  // ==========================================================================
  // Signals
  typedef struct packed {
    logic [15:0] phc;
    logic        spd;
    logic        dup;
    logic        col;
    logic [1:0]  exp;
  } pli_row_t;
  logic                 clk = 1'b0;
  logic                 rst_b, reg_wr, reg_rd, pd_req;
  logic [4:0]           reg_addr;
  logic [15:0]          reg_wdata, reg_rdata;
  logic                 speed_100, full_duplex, signal_detect, energy_state;
  logic                 link_pulse, link_pulse_bad, rx_packet_ok;
  pli_pkg::pli_mii_tx_t mii_tx, media_tx;
  pli_pkg::pli_mii_rx_t line_rx, mii_rx;
  logic [2:0]           led_lvl, indicator_o, indicator_oe;
  logic                 pin_lvl, pin_o, pin_oe, power_down;
  int                   failures, comparisons, n;
  // Mode table against {activity, speed}; strap 010 makes the speed pin active low
  pli_row_t             rows [7] = '{{16'h0020, 5'h10}, {16'h0020, 5'h01}, {16'h0040, 5'h1A},
    {16'h0040, 5'h01}, {16'h0000, 5'h07}, {16'h0000, 5'h1C}, {16'h0000, 5'h01}};
  logic [4:0]           ra [8] = '{5'h00, 5'h10, 5'h11, 5'h12, 5'h18, 5'h19, 5'h1C, 5'h05};
  logic [15:0]          rv [8] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
    16'h0020, 16'h0000, 16'h0000};

  pli_core #(.LINK_LOSS_CYC(100), .BLINK_UNIT_CYC(4)) pli_core_i (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .speed_100,
    .full_duplex, .signal_detect, .link_pulse, .link_pulse_bad, .rx_packet_ok, .energy_state,
    .mii_tx, .media_tx, .line_rx, .mii_rx, .indicator_i(led_lvl), .indicator_o, .indicator_oe,
    .powerdown_irq_pin_i(pin_lvl), .powerdown_irq_pin_o(pin_o),
    .powerdown_irq_pin_oe(pin_oe), .power_down);
  pli_pins_model pli_pins_model_i (.led_o(indicator_o), .led_oe(indicator_oe), .pin_o,
    .pin_oe, .pd_req, .led_lvl, .pin_lvl);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ==========================================================================
  // Tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // Lands just past an edge so that the edge's updates are settled
  task automatic see(input int k);
    cyc(k);
    #1;
  endtask : see
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    cyc(1);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    cyc(1);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask : rd
  task automatic pulses(input int k);
    repeat (k)
    begin
      cyc(1);
      link_pulse <= 1'b1;
      cyc(1);
      link_pulse <= 1'b0;
    end
  endtask : pulses
  // Counts link indicator changes over 48 cycles
  task automatic blinks(output int c);
    logic p;
    c = 0;
    p = led_lvl[0];
    repeat (48)
    begin
      see(1);
      c += int'(led_lvl[0] !== p);
      p = led_lvl[0];
    end
  endtask : blinks
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, pd_req, reg_addr, reg_wdata} = '0;
    {speed_100, full_duplex, signal_detect, energy_state} = '0;
    {link_pulse, link_pulse_bad, rx_packet_ok, mii_tx, line_rx} = '0;
    {failures, comparisons} = '0;
    cyc(5);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      wr(5'h19, rows[i].phc);
      speed_100 <= rows[i].spd;
      full_duplex <= rows[i].dup;
      line_rx.col <= rows[i].col;
      see(3);
      chk({14'h0000, led_lvl[2:1]}, {14'h0000, rows[i].exp});
    end
    $display("mode table done");
    // Reset in mid-run, then reset values and an unmapped read
    cyc(1);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(ra[i], rv[i]);
    $display("reset test done");
    // Broken pulse train, then seven good pulses, then the normal loss timer
    pulses(3);
    cyc(1);
    link_pulse_bad <= 1'b1;
    cyc(1);
    link_pulse_bad <= 1'b0;
    pulses(6);
    see(2);
    chk({15'h0000, led_lvl[0]}, 16'h0000);
    pulses(1);
    see(2);
    chk({15'h0000, led_lvl[0]}, 16'h0001);
    see(90);
    chk({15'h0000, led_lvl[0]}, 16'h0001);
    see(20);
    chk({15'h0000, led_lvl[0]}, 16'h0000);
    // 100M link from signal detect, then fast loss
    cyc(1);
    speed_100 <= 1'b1;
    signal_detect <= 1'b1;
    wr(5'h1C, 16'h0100);
    see(3);
    chk({15'h0000, led_lvl[0]}, 16'h0001);
    cyc(1);
    signal_detect <= 1'b0;
    see(56);
    chk({15'h0000, led_lvl[0]}, 16'h0000);
    $display("link test done");
    // Blinking on transmit activity, fastest rate, then receive-only activity
    wr(5'h19, 16'h0000);
    signal_detect <= 1'b1;
    mii_tx.en <= 1'b1;
    wr(5'h18, 16'h00C0);
    blinks(n);
    chk({15'h0000, n >= 4}, 16'h0001);
    wr(5'h18, 16'h01C0);
    blinks(n);
    chk({15'h0000, n < 2}, 16'h0001);
    // Direct force of every pin; the register reads back, not the pins
    wr(5'h18, 16'h003D);
    mii_tx.en <= 1'b0;
    see(3);
    chk({13'h0000, led_lvl}, 16'h0007);
    rd(5'h18, 16'h003D);
    wr(5'h18, 16'h0000);
    $display("indicator test done");
    // Loopback with negotiation left disabled, then back to the line
    wr(5'h00, 16'h4000);
    mii_tx <= 6'h2A;
    line_rx <= 8'h85;
    see(3);
    chk({2'h0, mii_rx, media_tx}, 16'h2A80);
    rd(5'h10, 16'h0008, 16'h0008);
    wr(5'h00, 16'h0000);
    see(3);
    chk({2'h0, mii_rx, media_tx}, 16'h216A);
    $display("loopback test done");
    // Pin-driven power down, left by the output enable; control bit power down
    cyc(1);
    pd_req <= 1'b1;
    see(1);
    chk({15'h0000, power_down}, 16'h0001);
    rd(5'h00, 16'h0000);
    wr(5'h11, 16'h0001);
    see(1);
    chk({14'h0000, pin_oe, power_down}, 16'h0002);
    cyc(1);
    pd_req <= 1'b0;
    wr(5'h00, 16'h0800);
    see(1);
    chk({15'h0000, power_down}, 16'h0001);
    rd(5'h00, 16'h0800);
    wr(5'h00, 16'h0000);
    // Interrupts: disabled, masked, raised, cleared, and an event during the clearing read
    energy_state <= 1'b1;
    see(2);
    chk({15'h0000, pin_lvl}, 16'h0001);
    rd(5'h12, 16'h0000);
    wr(5'h11, 16'h0003);
    wr(5'h12, 16'h0060);
    full_duplex <= ~full_duplex;
    see(2);
    chk({15'h0000, pin_lvl}, 16'h0001);
    cyc(1);
    energy_state <= 1'b0;
    see(2);
    chk({15'h0000, pin_lvl}, 16'h0000);
    rd(5'h12, 16'h4060);
    chk({15'h0000, pin_lvl}, 16'h0001);
    cyc(1);
    reg_addr <= 5'h12;
    reg_rd <= 1'b1;
    energy_state <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 16'h0060);
    chk({15'h0000, pin_lvl}, 16'h0000);
    rd(5'h12, 16'h4060);
    wr(5'h12, 16'h0040);
    rd(5'h12, 16'h0040);
    $display("interrupt test done");
    tally_and_finish();
  end

  // Watchdog against a hang
  initial
  begin
    cyc(3000);
    failures++;
    tally_and_finish();
  end
endmodule : pli_core_test
